// File: shared/tbf_pkg.sv
/*
 * tbf_pkg: register map, field layout, reset values and build options of the
 * transmit/receive buffer flow-control register bank.
 * Assumes: imported whole by every design file of the block.
 */
package tbf_pkg;

    // window of the block inside configuration space (byte addresses)
    localparam int unsigned ADDR_W = 24;
    localparam logic [23:0] BLOCK_BASE = 24'h010000;
    localparam logic [23:0] BLOCK_SPAN_MASK = 24'hfffff8;

    // register offsets relative to the block base
    localparam logic [2:0] OFS_PRIO_THRESHOLD_CONFIG = 3'h0;
    localparam logic [2:0] OFS_BUFFER_OPTION_CONTROL = 3'h4;

    // priority_threshold_config field layout
    localparam int unsigned THR_W = 6;
    localparam int unsigned PRIO0_LSB = 0;
    localparam int unsigned PRIO1_LSB = 8;
    localparam int unsigned PRIO2_LSB = 16;
    localparam int unsigned THR_LIMIT = 64;

    // recommended safe reset thresholds
    localparam logic [5:0] PRIO0_RESET = 6'h03;
    localparam logic [5:0] PRIO1_RESET = 6'h02;
    localparam logic [5:0] PRIO2_RESET = 6'h01;

    // buffer_option_control field layout
    localparam int unsigned RX_ONLY_BIT = 31;
    localparam int unsigned UNIFIED_CLK_BIT = 30;
    localparam int unsigned TX_FC_BIT = 29;
    localparam int unsigned TX_REORDER_BIT = 28;
    localparam int unsigned TX_SIZE_LSB = 16;
    localparam int unsigned TX_SIZE_W = 11;
    localparam int unsigned FORCE_RX_BIT = 15;
    localparam int unsigned RX_SIZE_LSB = 0;
    localparam int unsigned RX_SIZE_W = 8;

    // default build options
    localparam int unsigned TX_SIZE_DEFAULT = 32;
    localparam int unsigned RX_SIZE_DEFAULT = 32;
    localparam logic FORCE_RX_RESET = 1'b0;

    // width of the partner free-space count from the link layer
    localparam int unsigned FREE_W_DEFAULT = 6;

    localparam logic [31:0] READ_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        TBF_BUS_IDLE,
        TBF_BUS_ANSWER
    } tbf_bus_state_t;

endpackage

// File: hw/tbf_prio_gate.sv
/*
 * tbf_prio_gate: decides per priority whether a packet may be sent now,
 * from the partner's advertised free buffer space and the thresholds.
 * Assumes: all inputs come from logic on mclk_i; outputs are registered.
 */
`timescale 1ns/1ps

module tbf_prio_gate
    import tbf_pkg::*;
#(
    parameter int unsigned FREE_W = FREE_W_DEFAULT
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic tx_fc_active_i,
    input wire logic [FREE_W-1:0] partner_free_i,
    input wire logic [THR_W-1:0] prio0_threshold_i,
    input wire logic [THR_W-1:0] prio1_threshold_i,
    input wire logic [THR_W-1:0] prio2_threshold_i,
    output logic [2:0] prio_allow_o
);

    logic [THR_W-1:0] thr [3];
    logic [2:0] allow_d;
    logic [2:0] allow_q;

    assign thr[0] = prio0_threshold_i;
    assign thr[1] = prio1_threshold_i;
    assign thr[2] = prio2_threshold_i;

    // partner space must reach the threshold of the priority
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_prio
            always_comb begin
                if (tx_fc_active_i) begin
                    allow_d[g] = (partner_free_i >= FREE_W'(thr[g])); // R2
                end else begin
                    allow_d[g] = 1'b1; // R17
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            allow_q <= 3'h0;
        end else begin
            allow_q <= allow_d;
        end
    end

    assign prio_allow_o = allow_q;

endmodule

// File: hw/tbf_csr_bank.sv
/*
 * tbf_csr_bank: threshold and buffer option registers of the packet buffer
 * stage, as an Avalon-MM slave with waitrequest, plus the transmit gate.
 * Assumes: a single Avalon master on mclk_i presenting byte addresses of the
 * configuration space; the link layer supplies the partner free-space count
 * on the same clock; the integrator clocks both layers alike when UNIFIED_CLK.
 */
// Implementation choice: register access over Avalon-MM.
//
// Functional notes
// (R1) software keeps 64 > prio0 > prio1 > prio2 > 0
// (R2) thresholds only gate sending under transmitter flow control
// (R3) prio2_threshold read-write at bits 21:16
// (R4) prio1_threshold read-write at bits 13:8
// (R5) prio0_threshold read-write at bits 5:0
// (R6) software sizes thresholds; safe values 3,2,1
// (R7) software halts traffic before changing thresholds
// (R8) bit 31 reads one for receiver-only build
// (R9) bit 30 reports single-clock build; integrator matches clocks
// (R10) bit 29 reads one while transmitter flow control active
// (R11) bit 28 reports request reordering allowed
// (R12) bits 26:16 report transmit buffer size 8/16/32
// (R13) bit 15 forces receiver flow control
// (R14) receiver-only build ignores bit 15 writes
// (R15) bits 7:0 report receive buffer size 8/16/32
// (R16) registers decoded from offset 0x010000 in block
// (R17) receiver flow control ignores thresholds entirely
`timescale 1ns/1ps

module tbf_csr_bank
    import tbf_pkg::*;
#(
    parameter bit RX_ONLY = 1'b0,
    parameter bit UNIFIED_CLK = 1'b0,
    parameter bit TX_REORDER = 1'b0,
    parameter int unsigned TX_SIZE = TX_SIZE_DEFAULT,
    parameter int unsigned RX_SIZE = RX_SIZE_DEFAULT,
    parameter logic [5:0] PRIO0_INIT = PRIO0_RESET,
    parameter logic [5:0] PRIO1_INIT = PRIO1_RESET,
    parameter logic [5:0] PRIO2_INIT = PRIO2_RESET,
    parameter bit FORCE_RX_INIT = FORCE_RX_RESET,
    parameter int unsigned FREE_W = FREE_W_DEFAULT
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [FREE_W-1:0] partner_free_i,
    output logic [2:0] prio_allow_o,
    output logic tx_flow_ctrl_mode_o
);

    // build-time checks
    function automatic bit size_ok(input int unsigned sz);
        size_ok = (sz == 8) || (sz == 16) || (sz == 32);
    endfunction

    // refused at elaboration, before any logic is built
    if (!size_ok(TX_SIZE)) begin : g_bad_tx_size
        $error("transmit buffer size must be 8, 16 or 32");
    end
    if (!size_ok(RX_SIZE)) begin : g_bad_rx_size
        $error("receive buffer size must be 8, 16 or 32");
    end
    if (!((PRIO0_INIT > PRIO1_INIT) && (PRIO1_INIT > PRIO2_INIT) && (PRIO2_INIT > 6'h00))) begin : g_bad_init
        $error("reset thresholds must be strictly descending and nonzero");
    end
    if (FREE_W < THR_W) begin : g_bad_free_w
        $error("free-space count narrower than a threshold");
    end

    // decoding used by both the read and write paths
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [2:0] ofs);
        hit = ((addr & BLOCK_SPAN_MASK) == BLOCK_BASE) && (addr[2:0] == ofs); // R16
    endfunction

    // byte-lane merge of a six-bit threshold living in byte lane lsb/8
    function automatic logic [THR_W-1:0] merge_thr(input logic [THR_W-1:0] old_v,
                                                   input logic [31:0] wdata,
                                                   input logic [3:0] be,
                                                   input int unsigned lsb);
        merge_thr = be[lsb/8] ? wdata[lsb +: THR_W] : old_v;
    endfunction

    tbf_bus_state_t bus_state_q;
    tbf_bus_state_t bus_state_d;
    logic waitreq_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [THR_W-1:0] prio0_threshold_q;
    logic [THR_W-1:0] prio1_threshold_q;
    logic [THR_W-1:0] prio2_threshold_q;
    logic force_rx_q;
    logic tx_fc_q;
    logic tx_fc_d;
    logic wr_commit;
    logic wr_thr;
    logic wr_ctl;
    logic [31:0] thr_word;
    logic [31:0] ctl_word;

    localparam logic [TX_SIZE_W-1:0] TX_SIZE_FIELD = TX_SIZE_W'(TX_SIZE);
    localparam logic [RX_SIZE_W-1:0] RX_SIZE_FIELD = RX_SIZE_W'(RX_SIZE);

    // bus handshake: a request is answered with waitrequest low one cycle later
    always_comb begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            TBF_BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    bus_state_d = TBF_BUS_ANSWER;
                end
            end
            TBF_BUS_ANSWER: begin
                bus_state_d = TBF_BUS_IDLE;
            end
            default: begin
                bus_state_d = TBF_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bus_state_q <= TBF_BUS_IDLE;
            waitreq_q <= 1'b1;
        end else begin
            bus_state_q <= bus_state_d;
            waitreq_q <= (bus_state_d != TBF_BUS_ANSWER);
        end
    end

    // a write takes effect at the edge where waitrequest is sampled low
    assign wr_commit = avs_write_i && (bus_state_q == TBF_BUS_ANSWER);
    assign wr_thr = wr_commit && hit(avs_address_i, OFS_PRIO_THRESHOLD_CONFIG);
    assign wr_ctl = wr_commit && hit(avs_address_i, OFS_BUFFER_OPTION_CONTROL);

    // thresholds, one byte lane each
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prio0_threshold_q <= PRIO0_INIT;
            prio1_threshold_q <= PRIO1_INIT;
            prio2_threshold_q <= PRIO2_INIT;
        end else if (wr_thr) begin
            prio0_threshold_q <= merge_thr(prio0_threshold_q, avs_writedata_i, avs_byteenable_i, PRIO0_LSB); // R5
            prio1_threshold_q <= merge_thr(prio1_threshold_q, avs_writedata_i, avs_byteenable_i, PRIO1_LSB); // R4
            prio2_threshold_q <= merge_thr(prio2_threshold_q, avs_writedata_i, avs_byteenable_i, PRIO2_LSB); // R3
        end
    end

    // force bit: held at zero in a receiver-only build, where it means nothing
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            force_rx_q <= RX_ONLY ? 1'b0 : FORCE_RX_INIT;
        end else if (wr_ctl && avs_byteenable_i[FORCE_RX_BIT/8] && !RX_ONLY) begin // R14
            force_rx_q <= avs_writedata_i[FORCE_RX_BIT]; // R13
        end
    end

    // current flow-control mode
    assign tx_fc_d = !RX_ONLY && !force_rx_q; // R13

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_fc_q <= 1'b0;
        end else begin
            tx_fc_q <= tx_fc_d; // R10
        end
    end

    // read views; reserved bits stay zero
    always_comb begin
        thr_word = READ_ZERO;
        thr_word[PRIO0_LSB +: THR_W] = prio0_threshold_q; // R5
        thr_word[PRIO1_LSB +: THR_W] = prio1_threshold_q; // R4
        thr_word[PRIO2_LSB +: THR_W] = prio2_threshold_q; // R3
    end

    always_comb begin
        ctl_word = READ_ZERO;
        ctl_word[RX_ONLY_BIT] = RX_ONLY; // R8 R14
        ctl_word[UNIFIED_CLK_BIT] = UNIFIED_CLK; // R9
        ctl_word[TX_FC_BIT] = tx_fc_d; // R10
        ctl_word[TX_REORDER_BIT] = TX_REORDER; // R11
        ctl_word[TX_SIZE_LSB +: TX_SIZE_W] = TX_SIZE_FIELD; // R12
        ctl_word[FORCE_RX_BIT] = force_rx_q; // R13
        ctl_word[RX_SIZE_LSB +: RX_SIZE_W] = RX_SIZE_FIELD; // R15
    end

    // read data is captured when the request is first seen and held for the answer
    always_comb begin
        rdata_d = rdata_q;
        if (bus_state_q == TBF_BUS_IDLE && avs_read_i) begin
            if (hit(avs_address_i, OFS_PRIO_THRESHOLD_CONFIG)) begin
                rdata_d = thr_word;
            end else if (hit(avs_address_i, OFS_BUFFER_OPTION_CONTROL)) begin
                rdata_d = ctl_word;
            end else begin
                rdata_d = READ_ZERO;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_q <= READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // transmit gate per priority
    tbf_prio_gate #(
        .FREE_W(FREE_W)
    ) u_gate (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .tx_fc_active_i(tx_fc_d), // R2 R17
        .partner_free_i(partner_free_i),
        .prio0_threshold_i(prio0_threshold_q),
        .prio1_threshold_i(prio1_threshold_q),
        .prio2_threshold_i(prio2_threshold_q),
        .prio_allow_o(prio_allow_o)
    );

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = waitreq_q;
    assign tx_flow_ctrl_mode_o = tx_fc_q;

endmodule

// File: testbench/tbf_csr_bank_properties.sv
/* tbf_csr_bank_properties: port checks on the threshold and buffer option register bank.
   Assumes: bound to tbf_csr_bank; software keeps thresholds ordered, nonzero and below 64. */
`timescale 1ns/1ps
module tbf_csr_bank_properties
    import tbf_pkg::*;
#(
    parameter int unsigned FREE_W = FREE_W_DEFAULT
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [FREE_W-1:0] partner_free_i,
    input wire logic [2:0] prio_allow_o,
    input wire logic tx_flow_ctrl_mode_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic req;
    logic mapped;
    logic rd_ack;
    assign req = avs_read_i || avs_write_i;
    assign mapped = (avs_address_i & BLOCK_SPAN_MASK) == BLOCK_BASE;
    assign rd_ack = !avs_waitrequest_o && avs_read_i;
    a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_answer_next: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered in the following cycle");
    a_no_spurious_ack: assert property ($fell(avs_waitrequest_o) |-> $past(req))
        else $error("waitrequest dropped without a request");
    a_unmapped_zero: assert property (rd_ack && !mapped |-> avs_readdata_o == READ_ZERO)
        else $error("unmapped read returned nonzero data");
    a_thr_reserved: assert property (rd_ack && avs_address_i == BLOCK_BASE |->
        (avs_readdata_o & 32'hffc0c0c0) == READ_ZERO) else $error("threshold reserved bits nonzero");
    a_mode_bit_read: assert property (rd_ack && avs_address_i == (BLOCK_BASE | 24'h000004) |->
        avs_readdata_o[29] == tx_flow_ctrl_mode_o && !avs_readdata_o[27]) else $error("mode bit mismatch");
    a_readdata_hold: assert property (!$past(avs_read_i) |-> $stable(avs_readdata_o))
        else $error("read data changed without a read");
    a_rx_all_allowed: assert property (!tx_flow_ctrl_mode_o && $past(rst_n_i) |-> prio_allow_o == 3'h7)
        else $error("receiver flow control did not allow all priorities");
    a_allow_ordered: assert property (prio_allow_o inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("priority allowance out of order");
    a_empty_blocks: assert property (tx_flow_ctrl_mode_o && $past(tx_flow_ctrl_mode_o) &&
        $past(partner_free_i) == '0 |-> prio_allow_o == 3'h0) else $error("sent with no partner space");
    a_full_allows: assert property ($past(rst_n_i) && $past(partner_free_i) == '1 |-> prio_allow_o == 3'h7)
        else $error("full partner space did not allow all");
endmodule

// File: testbench/tbf_csr_bank_bench.sv
/* tbf_csr_bank_bench: directed register, decode and gate tests of tbf_csr_bank.
   Assumes: default build options for tbf_csr_bank_i (transmitter flow control, 32-entry buffers, no reorder); tbf_csr_bank_ro_i overrides them. */
`timescale 1ns/1ps
module tbf_csr_bank_bench
    import tbf_pkg::*;
;
    localparam logic [23:0] THR_A = BLOCK_BASE;
    localparam logic [23:0] CTRL_A = BLOCK_BASE | 24'h000004;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [23:0] avs_address_i = 24'h000000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [5:0] partner_free_i = 6'h00;
    logic [2:0] prio_allow_o;
    logic tx_flow_ctrl_mode_o;
    int bad_count = 0;
    int compares = 0;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [31:0] ro_readdata;
    logic ro_waitrequest;
    logic [2:0] ro_allow;
    logic ro_mode;
    logic [5:0] fv [8] = '{6'h00, 6'h0f, 6'h10, 6'h1f, 6'h20, 6'h2f, 6'h30, 6'h3f};
    logic [2:0] ev [8] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h6, 3'h6, 3'h7, 3'h7};

    always #2.5 mclk_i = ~mclk_i;

    tbf_csr_bank tbf_csr_bank_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .partner_free_i(partner_free_i),
        .prio_allow_o(prio_allow_o), .tx_flow_ctrl_mode_o(tx_flow_ctrl_mode_o));

    // receiver-only, single-clock, reordering build sharing the same bus requests
    tbf_csr_bank #(.RX_ONLY(1'b1), .UNIFIED_CLK(1'b1), .TX_REORDER(1'b1), .TX_SIZE(8), .RX_SIZE(16))
        tbf_csr_bank_ro_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(ro_readdata),
        .avs_waitrequest_o(ro_waitrequest), .partner_free_i(partner_free_i),
        .prio_allow_o(ro_allow), .tx_flow_ctrl_mode_o(ro_mode));

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one bus access; waits for waitrequest low, then releases and lets one edge pass
    task automatic xfer(input logic wr, input logic [23:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin
            bad_count++;
            $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest_o);
            summarize();
        end
        rd = avs_readdata_o;
        rd2 = ro_readdata;
        check("ro_waitrequest", 32'h0, {31'h0, ro_waitrequest});
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rchk(input string name, input logic [23:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000, 4'hf);
        check(name, exp, rd);
    endtask

    task automatic gate(input logic [5:0] v, input logic [2:0] e);
        partner_free_i <= v;
        repeat (2) @(posedge mclk_i);
        check("prio_allow", {29'h0, e}, {29'h0, prio_allow_o});
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rchk("thr_reset", THR_A, 32'h00010203);
        rchk("ctrl_reset", CTRL_A, 32'h20200020);
        check("ro_ctrl_reset", 32'hd0080010, rd2);
        check("tx_mode", 32'h1, {31'h0, tx_flow_ctrl_mode_o});
        gate(6'h02, 3'h6);
        $display("test reset values done");
        xfer(1'b1, THR_A, 32'hffd0e0f0, 4'hf);
        rchk("thr_write", THR_A, 32'h00102030);
        for (int i = 0; i < 8; i++) begin
            gate(fv[i], ev[i]);
        end
        xfer(1'b1, THR_A, 32'h0000003f, 4'h1);
        rchk("thr_lane", THR_A, 32'h0010203f);
        $display("test thresholds done");
        xfer(1'b1, CTRL_A, 32'h00008000, 4'h2);
        rchk("ctrl_force", CTRL_A, 32'h00208020);
        check("ro_ctrl_force", 32'hd0080010, rd2);
        gate(6'h00, 3'h7);
        check("rx_mode", 32'h0, {31'h0, tx_flow_ctrl_mode_o});
        check("ro_mode", 32'h0, {31'h0, ro_mode});
        check("ro_allow", 32'h7, {29'h0, ro_allow});
        xfer(1'b1, CTRL_A, 32'hffff7fff, 4'hd);
        rchk("ctrl_ro", CTRL_A, 32'h00208020);
        xfer(1'b1, CTRL_A, 32'h00000000, 4'hf);
        rchk("ctrl_clear", CTRL_A, 32'h20200020);
        gate(6'h00, 3'h0);
        check("ro_allow_empty", 32'h7, {29'h0, ro_allow});
        $display("test force done");
        xfer(1'b1, BLOCK_BASE | 24'h000008, 32'hffffffff, 4'hf);
        rchk("unmapped", BLOCK_BASE | 24'h000008, 32'h00000000);
        rchk("low_space", 24'h000000, 32'h00000000);
        rchk("thr_kept", THR_A, 32'h0010203f);
        $display("test decode done");
        summarize();
    end

    initial begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule

bind tbf_csr_bank tbf_csr_bank_properties #(.FREE_W(FREE_W)) tbf_csr_bank_properties_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .partner_free_i(partner_free_i), .prio_allow_o(prio_allow_o),
    .tx_flow_ctrl_mode_o(tx_flow_ctrl_mode_o));
